//--- travel_distance_life_monitor.sv
// Total travel distance life monitor with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none

module travel_distance_life_monitor
	import travel_life_pkg::*;
(
	// Clock, reset, enable
	input wire logic I_REF_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_CLK_EN,
	// AHB-Lite slave
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	// Encoder and controller pins
	input wire logic I_ENC_STEP,
	input wire logic I_CTRL_RST,
	// Warning and interrupt
	output logic O_WARN,
	output logic O_IRQ
);

	typedef struct packed {
		select_type sel;
		logic [31:0] thresh;
		logic [31:0] offset;
		logic [31:0] accum;
		logic [IRQ_COUNT-1:0] status;
		logic [IRQ_COUNT-1:0] mask;
		logic warn;
		logic irq;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic hready;
		logic hresp;
		logic step_s1;
		logic step_s2;
		logic step_prev;
		logic crst_s1;
		logic crst_s2;
		logic crst_prev;
	} state_type;

	localparam state_type ST_RESET = '{
		sel: SEL_DISABLE,
		thresh: THRESH_RESET,
		offset: OFFSET_RESET,
		accum: ACCUM_RESET,
		mask: MASK_RESET,
		hready: 1'b1,
		hresp: HRESP_OKAY,
		default: '0
	};

	state_type st;
	state_type next_st;
	logic unit_pulse;
	logic step_edge;
	logic clear_div;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Clamps at all ones so a long-lived axis never wraps to a small total
	function automatic logic [31:0] sat_add(input logic [31:0] a,
			input logic [31:0] b);
		logic [32:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		if (sum[32]) begin
			sat_add = TOTAL_MAX;
		end else begin
			sat_add = sum[31:0];
		end
	endfunction

	function automatic logic [31:0] read_mux(input logic [7:0] addr,
			input state_type s, input logic [31:0] total);
		read_mux = 32'h0000_0000;
		case (addr)
			OFS_CTRL: begin
				read_mux[CTRL_SEL_LSB +: 2] = s.sel;
			end
			OFS_THRESH: begin
				read_mux = s.thresh;
			end
			OFS_OFFSET: begin
				read_mux = s.offset;
			end
			OFS_TOTAL: begin
				read_mux = total;
			end
			OFS_STATUS: begin
				read_mux[IRQ_COUNT-1:0] = s.status;
			end
			OFS_MASK: begin
				read_mux[IRQ_COUNT-1:0] = s.mask;
			end
			OFS_STATE: begin
				read_mux[STATE_ACTIVE_BIT] = (s.sel == SEL_ENABLE);
				read_mux[STATE_WARN_BIT] = s.warn;
				read_mux[STATE_PEND_BIT] = (s.sel == SEL_RESET);
			end
			default: begin
				read_mux = 32'h0000_0000;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Count to distance units

	assign step_edge = st.step_s2 & ~st.step_prev;

	travel_unit_divider u_divider (
		.i_clk(I_REF_CLK),
		.i_rst(I_SYS_RST),
		.i_ce(I_CLK_EN),
		.i_count(step_edge),
		.i_clear(clear_div),
		.o_unit(unit_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [31:0] total;
		logic [31:0] bumped;
		logic [IRQ_COUNT-1:0] ev;
		logic [IRQ_COUNT-1:0] clr;
		logic soft_rst;
		logic crst_edge;
		logic addr_ok;
		state_type view;

		next_st = st;
		total = 32'h0000_0000;
		bumped = 32'h0000_0000;
		ev = '0;
		clr = '0;
		soft_rst = 1'b0;
		clear_div = 1'b0;
		crst_edge = 1'b0;
		addr_ok = 1'b0;
		view = st;

		// Pin synchronisers
		next_st.step_s1 = I_ENC_STEP;
		next_st.step_s2 = st.step_s1;
		next_st.step_prev = st.step_s2;
		next_st.crst_s1 = I_CTRL_RST;
		next_st.crst_s2 = st.crst_s1;
		next_st.crst_prev = st.crst_s2;
		crst_edge = st.crst_s2 & ~st.crst_prev;

		total = sat_add(st.accum, st.offset);

		// Accumulate distance magnitude; direction is ignored
		if (unit_pulse) begin
			bumped = sat_add(st.accum, 32'h0000_0001);
			next_st.accum = bumped;
			if (bumped == TOTAL_MAX && st.accum != TOTAL_MAX) begin
				ev[IRQ_SATURATED] = 1'b1;
			end
		end

		// Register write data phase
		if (st.wr_pend) begin
			case (st.wr_addr)
				OFS_CTRL: begin
					// Code three is unused; such a write keeps the mode
					if (I_HWDATA[CTRL_SEL_LSB +: 2] != 2'b11) begin
						next_st.sel = select_type'(
							I_HWDATA[CTRL_SEL_LSB +: 2]);
					end
					soft_rst = I_HWDATA[CTRL_SOFT_RST_BIT];
				end
				OFS_THRESH: begin
					next_st.thresh = I_HWDATA;
				end
				OFS_OFFSET: begin
					next_st.offset = I_HWDATA;
				end
				OFS_STATUS: begin
					clr = I_HWDATA[IRQ_COUNT-1:0];
				end
				OFS_MASK: begin
					next_st.mask = I_HWDATA[IRQ_COUNT-1:0];
				end
				default: begin
					clr = '0;
				end
			endcase
		end

		// Deferred clear; last so it overrides a count in the same cycle
		if ((soft_rst || crst_edge) && st.sel == SEL_RESET) begin
			next_st.accum = ACCUM_RESET;
			next_st.sel = SEL_ENABLE;
			clear_div = 1'b1;
		end

		// Warning compare
		next_st.warn = (st.sel == SEL_ENABLE)
			&& (st.thresh != 32'h0000_0000)
			&& (total > st.thresh);
		if (next_st.warn && !st.warn) begin
			ev[IRQ_WARN_RISE] = 1'b1;
		end

		// Sticky status; a new event beats a same-cycle clear
		for (int i = 0; i < IRQ_COUNT; i++) begin
			next_st.status[i] = ev[i] | (st.status[i] & ~clr[i]);
		end
		next_st.irq = |(next_st.status & next_st.mask);

		// Address phase; zero wait states, reads latched here
		// Reads see the state after this edge, so a read right
		// behind a write returns the freshly written value
		view = next_st;
		addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
		next_st.wr_pend = addr_ok && I_HWRITE && (I_HSIZE == HSIZE_WORD);
		next_st.wr_addr = I_HADDR[7:0];
		if (addr_ok && !I_HWRITE) begin
			next_st.rdata = read_mux(I_HADDR[7:0], view,
				sat_add(view.accum, view.offset));
		end
		next_st.hready = 1'b1;
		next_st.hresp = HRESP_OKAY;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Power-on reset is the power cycle: everything, the total too, clears
	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			st <= ST_RESET;
		end else if (I_CLK_EN) begin
			st <= next_st;
		end
	end

	assign O_HRDATA = st.rdata;
	assign O_HREADYOUT = st.hready;
	assign O_HRESP = st.hresp;
	assign O_WARN = st.warn;
	assign O_IRQ = st.irq;

endmodule
`default_nettype wire

//--- travel_life_pkg.sv
// Constants, types and register map of the travel life monitor
package travel_life_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_THRESH = 8'h04;
	localparam logic [7:0] OFS_OFFSET = 8'h08;
	localparam logic [7:0] OFS_TOTAL = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_STATE = 8'h18;

	// Control register fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_SOFT_RST_BIT = 8;

	// Status, mask and state fields
	localparam int IRQ_WARN_RISE = 0;
	localparam int IRQ_SATURATED = 1;
	localparam int IRQ_COUNT = 2;
	localparam int STATE_ACTIVE_BIT = 0;
	localparam int STATE_WARN_BIT = 1;
	localparam int STATE_PEND_BIT = 2;

	// Reset values
	localparam logic [31:0] THRESH_RESET = 32'h0000_0000;
	localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
	localparam logic [31:0] ACCUM_RESET = 32'h0000_0000;
	localparam logic [IRQ_COUNT-1:0] MASK_RESET = 2'h0;
	localparam logic [31:0] TOTAL_MAX = 32'hFFFF_FFFF;

	// Encoder counts per unit of ten revolutions (or one metre)
	localparam logic [15:0] COUNTS_PER_UNIT = 16'h000A;

	// AHB-Lite codes
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		SEL_DISABLE = 2'b00,
		SEL_ENABLE = 2'b01,
		SEL_RESET = 2'b10
	} select_type;

endpackage

//--- travel_unit_divider.sv
// Divides encoder counts down to distance units
`timescale 1ns/1ns
`default_nettype none

module travel_unit_divider
	import travel_life_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Counts in, units out
	input wire logic i_count,
	input wire logic i_clear,
	output logic o_unit
);

	typedef struct packed {
		logic [15:0] cnt;
		logic unit;
	} div_state_type;

	div_state_type st;
	div_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.unit = 1'b0;
		if (i_clear) begin
			next_st.cnt = 16'h0000;
		end else if (i_count) begin
			if (st.cnt == COUNTS_PER_UNIT - 16'h0001) begin
				next_st.cnt = 16'h0000;
				next_st.unit = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_unit = st.unit;

endmodule
`default_nettype wire

//--- tlm_assertions.sv
// Port-level checker for the travel life monitor
`timescale 1ns/1ns
`default_nettype none
module tlm_assertions
	import travel_life_pkg::*;
(
	// Watched ports
	input wire logic I_REF_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	input wire logic [31:0] O_HRDATA,
	input wire logic O_HREADYOUT,
	input wire logic O_HRESP,
	input wire logic O_WARN,
	input wire logic O_IRQ
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);
	wire take = I_HSEL && I_HTRANS[1] && I_HREADY;
	// Register updates on the data edge, O_WARN one edge later, O_IRQ on the same edge
	sequence wr(logic [7:0] a, logic [31:0] d);
		take && I_HWRITE && I_HADDR[7:0] == a ##1 I_HWDATA == d;
	endsequence
	AST_READY: assert property (O_HREADYOUT)
		else $error("hreadyout low");
	AST_OKAY: assert property (O_HRESP == HRESP_OKAY)
		else $error("bad response");
	AST_HOLE: assert property (take && !I_HWRITE && I_HADDR[7:0] == 8'h1C
		|=> O_HRDATA == 32'h0) else $error("unmapped data");
	AST_DIS: assert property (wr(OFS_CTRL, 32'h0) |-> ##2 !O_WARN)
		else $error("warn after disable");
	AST_ZERO: assert property (wr(OFS_THRESH, 32'h0) |-> ##2 !O_WARN)
		else $error("warn at zero limit");
	AST_HIGH: assert property (
		wr(OFS_THRESH, 32'hFFFF_FFFF) |-> ##2 !O_WARN)
		else $error("warn above total");
	AST_PEND: assert property (wr(OFS_CTRL, 32'h2) |-> ##2 !O_WARN)
		else $error("warn while pending");
	AST_MASK: assert property (wr(OFS_MASK, 32'h0) |-> ##2 !O_IRQ)
		else $error("irq while masked");
	cover property (wr(OFS_CTRL, 32'h100));
	cover property ($rose(O_WARN));
	cover property ($rose(O_IRQ));
endmodule
`default_nettype wire

//--- enc_model.sv
// Encoder partner: emits a counted burst of steps
`timescale 1ns/1ns
`default_nettype none
module enc_model (
	// Control
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [15:0] i_steps,
	// Encoder pin
	output logic o_step,
	output logic o_busy
);
	// Two clocks high, two low: half the fastest rate the sync allows
	logic [17:0] phase = 18'h0;
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			phase <= {i_steps, 2'b00};
		end else if (phase != 18'h0) begin
			phase <= phase - 18'h1;
		end
	end
	assign o_step = phase[1];
	assign o_busy = phase != 18'h0;
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the travel life monitor
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import travel_life_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic crst = 1'b0;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic [2:0] hsize = HSIZE_WORD;
	logic [1:0] htrans = 2'h0;
	logic [15:0] nsteps = 16'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q;
	logic step, busy, warn, irq;
	wire logic hready;
	int failures = 0;
	int total_checks = 0;
	always #25 clk = ~clk;
	enc_model u_enc_model (.i_clk(clk), .i_go(go), .i_steps(nsteps),
		.o_step(step), .o_busy(busy));
	travel_distance_life_monitor u_travel_distance_life_monitor (
		.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(ce), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
		.O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(),
		.I_ENC_STEP(step), .I_CTRL_RST(crst), .O_WARN(warn), .O_IRQ(irq));
	task automatic results;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e, input string n);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rdy;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (hready === 1'b1) return;
		end
		failures++;
		results;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		chk(q, e, n);
	endtask
	// Warning settles one edge after the register write lands
	task automatic wv(input logic [7:0] a, logic [31:0] d, logic e);
		bus(1'b1, a, d);
		repeat (2) @(posedge clk);
		chk({31'h0, warn}, {31'h0, e}, "warn");
	endtask
	task automatic move(input logic [15:0] n);
		int i;
		go <= 1'b1;
		nsteps <= n;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk);
		if (i == 1000) begin
			failures++;
			results;
		end
		repeat (8) @(posedge clk);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(OFS_THRESH, 32'h0, "thresh");
		rc(OFS_OFFSET, 32'h0, "offset");
		rc(8'h1C, 32'h0, "hole");
		bus(1'b1, OFS_OFFSET, 32'h5);
		rc(OFS_TOTAL, 32'h5, "total");
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b1, OFS_MASK, 32'h1);
		wv(OFS_THRESH, 32'h7, 1'b0);
		move(16'd30);
		chk({31'h0, warn}, 32'h1, "warn");
		chk({31'h0, irq}, 32'h1, "irq");
		rc(OFS_STATE, 32'h3, "state");
		rc(OFS_TOTAL, 32'h8, "total");
		rc(OFS_STATUS, 32'h1, "status");
		wv(OFS_STATUS, 32'h1, 1'b1);
		chk({31'h0, irq}, 32'h0, "irq");
		wv(OFS_THRESH, 32'h8, 1'b0);
		wv(OFS_THRESH, 32'h0, 1'b0);
		wv(OFS_THRESH, 32'h7, 1'b1);
		wv(OFS_THRESH, 32'hFFFF_FFFF, 1'b0);
		wv(OFS_THRESH, 32'h7, 1'b1);
		wv(OFS_CTRL, 32'h0, 1'b0);
		wv(OFS_CTRL, 32'h2, 1'b0);
		rc(OFS_STATE, 32'h4, "state");
		rc(OFS_TOTAL, 32'h8, "kept");
		bus(1'b1, OFS_CTRL, 32'h100);
		rc(OFS_CTRL, 32'h1, "select");
		rc(OFS_TOTAL, 32'h5, "cleared");
		// Steps while the clock enable is low must not count
		ce <= 1'b0;
		move(16'd10);
		ce <= 1'b1;
		rc(OFS_TOTAL, 32'h5, "frozen");
		move(16'd10);
		bus(1'b1, OFS_CTRL, 32'h2);
		crst <= 1'b1;
		repeat (4) @(posedge clk);
		crst <= 1'b0;
		repeat (6) @(posedge clk);
		rc(OFS_CTRL, 32'h1, "select");
		rc(OFS_TOTAL, 32'h5, "cleared");
		bus(1'b1, OFS_CTRL, 32'h3);
		rc(OFS_CTRL, 32'h1, "keep");
		hsize <= 3'h0;
		bus(1'b1, OFS_THRESH, 32'h1);
		hsize <= HSIZE_WORD;
		rc(OFS_THRESH, 32'h7, "size");
		bus(1'b1, OFS_MASK, 32'h0);
		bus(1'b1, OFS_OFFSET, 32'hFFFF_FFFF);
		// Non-zero distance so a wrapping sum would read small
		move(16'd10);
		rc(OFS_TOTAL, 32'hFFFF_FFFF, "sat");
		chk({31'h0, warn}, 32'h1, "warn");
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(OFS_CTRL, 32'h0, "power");
		rc(OFS_TOTAL, 32'h0, "power");
		chk({31'h0, warn}, 32'h0, "warn");
		results;
	end
endmodule
bind travel_distance_life_monitor tlm_assertions u_tlm_assertions (
	.I_REF_CLK(I_REF_CLK),
	.I_SYS_RST(I_SYS_RST),
	.I_HSEL(I_HSEL),
	.I_HADDR(I_HADDR),
	.I_HTRANS(I_HTRANS),
	.I_HWRITE(I_HWRITE),
	.I_HWDATA(I_HWDATA),
	.I_HREADY(I_HREADY),
	.O_HRDATA(O_HRDATA),
	.O_HREADYOUT(O_HREADYOUT),
	.O_HRESP(O_HRESP),
	.O_WARN(O_WARN),
	.O_IRQ(O_IRQ)
);
`default_nettype wire
